// [bench/sci_uart_receiver_wakeup_tb.sv]
// Self-checking bench for the serial receiver with wakeup
`timescale 1ns/100ps
`default_nettype none
module sci_uart_receiver_wakeup_tb import sci_pkg::*;;
  logic              ref_clk, rst, psel, penable, pwrite, pready, pslverr, rxd, txd, irq, rerr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata;
  logic [7:0]        rdv;
  int                failures, total_checks, m_buf;
  bit                m_full, m_ovr, m_fe, m_nf, m_r8, m_sleep, m_addr, m_nine, m_en;

  sci_uart_receiver_wakeup #(.RT_DIV(1)) i_dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd(rxd), .txd(txd), .irq(irq));
  serial_node_model #(.BIT_CLKS(16)) i_node (.ref_clk(ref_clk), .line_in(txd), .line_out(rxd));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) failures++;
    rdv = prdata[7:0];
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Sends one frame and updates the reference model of the receiver
  task frame(input int d, input bit stop, input int gl);
    bit msb;
    msb = m_nine ? d[8] : d[7];
    i_node.send(d[8:0], m_nine ? 9 : 8, stop, gl);
    repeat (6) @(posedge ref_clk);
    if (m_addr && msb) m_sleep = 1'b0;
    if (m_en && !m_sleep) begin
      if (m_full) begin
        m_ovr = 1'b1;
      end else begin
        m_full = 1'b1;
        m_buf = d;
        m_r8 = d[8];
        m_fe = !stop;
        m_nf = (gl >= 0);
      end
    end
  endtask : frame

  // Status read, data read, then status again to see the flags gone
  task rx_check;
    apb(1'b0, IDX_STATUS, 8'h00);
    chk("status", {2'b00, m_full, 1'b0, m_ovr, m_nf, m_fe, 1'b0}, rdv & 8'h2e);
    apb(1'b0, IDX_DATA, 8'h00);
    if (m_full) chk("data", m_buf[7:0], rdv);
    {m_full, m_ovr, m_nf, m_fe} = 4'h0;
    apb(1'b0, IDX_STATUS, 8'h00);
    chk("cleared", 8'h00, rdv & 8'h2e);
  endtask : rx_check

  task test_done;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done

  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    test_done;
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    rst = 1'b1;
    void'($urandom(49077));
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    apb(1'b0, IDX_STATUS, 8'h00);
    chk("status", STATUS_RST, rdv);
    apb(1'b0, IDX_CTRL_TWO, 8'h00);
    chk("ctrl_two", CTRL_TWO_RST, rdv);
    apb(1'b0, 16'h1030, 8'h00);
    chk("slverr", 8'h01, {7'h0, rerr});
    chk("unmapped", 8'h00, rdv);
    chk("txd", 8'h01, {7'h0, txd});
    $display("test reset done");
    m_en = 1'b1;
    apb(1'b1, IDX_CTRL_TWO, 8'h24);
    frame($urandom_range(255), 1'b1, -1);
    chk("irq", 8'h01, {7'h0, irq});
    rx_check;
    repeat (3) @(posedge ref_clk);
    chk("irq", 8'h00, {7'h0, irq});
    $display("test receive done");
    frame($urandom_range(255), 1'b1, -1);
    frame($urandom_range(255), 1'b0, -1);
    rx_check;
    $display("test overrun done");
    frame($urandom_range(255), 1'b0, -1);
    rx_check;
    $display("test framing done");
    for (int g = 0; g <= 9; g += 3) begin
      frame($urandom_range(255), 1'b1, g);
      rx_check;
    end
    $display("test noise done");
    m_en = 1'b0;
    apb(1'b1, IDX_CTRL_TWO, 8'h20);
    frame($urandom_range(255), 1'b1, -1);
    rx_check;
    $display("test disabled done");
    m_en = 1'b1;
    m_nine = 1'b1;
    apb(1'b1, IDX_CTRL_TWO, 8'h24);
    apb(1'b1, IDX_CTRL_ONE, 8'h10);
    frame($urandom_range(511), 1'b1, -1);
    apb(1'b0, IDX_CTRL_ONE, 8'h00);
    chk("ctrl_one", {m_r8, 7'h10}, rdv);
    rx_check;
    $display("test nine bit done");
    m_nine = 1'b0;
    m_addr = 1'b1;
    apb(1'b1, IDX_CTRL_ONE, 8'h08);
    m_sleep = 1'b1;
    apb(1'b1, IDX_CTRL_TWO, 8'h26);
    frame($urandom_range(127), 1'b1, 1);
    rx_check;
    frame(8'h80 | $urandom_range(127), 1'b1, -1);
    apb(1'b0, IDX_CTRL_TWO, 8'h00);
    chk("ctrl_two", 8'h24, rdv);
    rx_check;
    $display("test address wake done");
    m_addr = 1'b0;
    apb(1'b1, IDX_CTRL_ONE, 8'h00);
    fork
      frame($urandom_range(255), 1'b1, -1);
      begin
        repeat (20) @(posedge ref_clk);
        m_sleep = 1'b1;
        apb(1'b1, IDX_CTRL_TWO, 8'h26);
      end
    join
    apb(1'b0, IDX_CTRL_TWO, 8'h00);
    chk("ctrl_two", 8'h26, rdv);
    rx_check;
    i_node.gap(12);
    m_sleep = 1'b0;
    apb(1'b0, IDX_CTRL_TWO, 8'h00);
    chk("ctrl_two", 8'h24, rdv);
    frame($urandom_range(255), 1'b1, -1);
    rx_check;
    $display("test idle wake done");
    test_done;
  end
endmodule : sci_uart_receiver_wakeup_tb
`default_nettype wire

// [bench/serial_node_model.sv]
// Remote serial node that drives the receive line of the block
`timescale 1ns/100ps
`default_nettype none
module serial_node_model #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic ref_clk,
  input  wire logic line_in,
  output logic      line_out
);
  logic b;

  initial line_out = 1'b1;

  // Start, data LSB first, stop; gl picks one bit that carries a one-tick glitch
  task automatic send(input logic [8:0] d, input int n, input logic stop, input int gl);
    for (int i = 0; i < n + 2; i++) begin
      b = (i == 0) ? 1'b0 : (i == n + 1) ? stop : d[i-1];
      for (int t = 0; t < BIT_CLKS; t++) begin
        @(posedge ref_clk);
        line_out <= (i == gl && t == 8) ? ~b : b;
      end
    end
    @(posedge ref_clk);
    line_out <= 1'b1;
  endtask : send

  // Quiet line between messages
  task automatic gap(input int bits);
    repeat (bits * BIT_CLKS) @(posedge ref_clk);
  endtask : gap
endmodule : serial_node_model
`default_nettype wire

// [src/bit_vote.sv]
// Majority vote over three samples of one bit
`timescale 1ns/100ps
`default_nettype none
module bit_vote import sci_pkg::*; (
  input  wire logic [2:0] samples,
  output logic            value,
  output logic            noisy
);
  assign value = (samples[0] & samples[1]) | (samples[0] & samples[2]) | (samples[1] & samples[2]);
  // Anything but a unanimous decision counts as noise
  assign noisy = (samples != 3'h0) && (samples != 3'h7);
endmodule : bit_vote
`default_nettype wire

// [src/rt_tick_gen.sv]
// Divider that makes the sixteen-times sampling tick
`timescale 1ns/100ps
`default_nettype none
module rt_tick_gen import sci_pkg::*; #(
  parameter int DIV = RT_DIV_DEFAULT
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  output logic      rt_tick
);
  logic [15:0] div_cnt;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      div_cnt <= 16'h0000;
      rt_tick <= 1'b0;
    end else if (div_cnt == 16'(DIV - 1)) begin
      div_cnt <= 16'h0000;
      rt_tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
      rt_tick <= 1'b0;
    end
  end
endmodule : rt_tick_gen
`default_nettype wire

// [src/sci_pkg.sv]
// Constants, register map and types of the serial receiver block
package sci_pkg;
  // Register indices; the byte address is four times the index
  localparam logic [15:0] IDX_CTRL_ONE = 16'h102c;
  localparam logic [15:0] IDX_CTRL_TWO = 16'h102d;
  localparam logic [15:0] IDX_STATUS   = 16'h102e;
  localparam logic [15:0] IDX_DATA     = 16'h102f;
  localparam int          ADDR_W       = 18;

  localparam logic [7:0] CTRL_TWO_RST = 8'h00;
  localparam logic [7:0] STATUS_RST   = 8'hc0;

  // First control register fields
  localparam int C1_RX_NINTH  = 7;
  localparam int C1_TX_NINTH  = 6;
  localparam int C1_FRAME_LEN = 4;
  localparam int C1_WAKE      = 3;

  // Second control register fields
  localparam int C2_TX_EMPTY_IE = 7;
  localparam int C2_TX_DONE_IE  = 6;
  localparam int C2_RX_FULL_IE  = 5;
  localparam int C2_QUIET_IE    = 4;
  localparam int C2_TX_EN       = 3;
  localparam int C2_RX_EN       = 2;
  localparam int C2_SLEEP       = 1;
  localparam int C2_BREAK       = 0;

  // Status register fields
  localparam int ST_TX_EMPTY = 7;
  localparam int ST_TX_DONE  = 6;
  localparam int ST_RX_FULL  = 5;
  localparam int ST_IDLE     = 4;
  localparam int ST_OVERRUN  = 3;
  localparam int ST_NOISE    = 2;
  localparam int ST_FRAMING  = 1;

  // Sixteen sampling ticks per bit, votes at ticks 7, 8 and 9
  localparam logic [3:0] RT_VOTE_FIRST = 4'h7;
  localparam logic [3:0] RT_VOTE_MID   = 4'h8;
  localparam logic [3:0] RT_VOTE_LAST  = 4'h9;
  localparam logic [3:0] RT_BIT_END    = 4'hf;

  localparam logic [3:0] DATA_BITS_8  = 4'h8;
  localparam logic [3:0] DATA_BITS_9  = 4'h9;
  localparam logic [3:0] FRAME_BITS_8 = 4'ha;
  localparam logic [3:0] FRAME_BITS_9 = 4'hb;

  localparam int RT_DIV_DEFAULT = 4;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;
endpackage : sci_pkg

// [src/sci_uart_receiver_wakeup.sv]
// Serial receiver with wakeup, control registers and small transmitter
//
// Overview of operation
// - Shift register fills a receive buffer; next character shifts in meanwhile.
// - Three samples per bit, majority vote decides value and cleanliness.
// - Sleep blocks full, idle, overrun, noise and framing flags; software may clear sleep.
// - Idle-line wakeup clears sleep when the line is seen idle.
// - Address-mark wakeup clears sleep before the stop bit of a marked character.
// - Marked characters carry seven or eight information bits plus a mark bit.
// - Completed character while buffer full sets overrun, drops it, keeps buffer.
// - Overrun clears by status read with it set, then data read.
// - Noise on any bit sets noise flag, only when buffer-full sets.
// - Stop bit not one sets framing flag together with buffer-full.
// - Framing plus overrun on one character reports only overrun.
// - Framing flag blocks further transfers into the buffer.
// - Framing flag clears by status read with it set, then data read.
// - Data register reads the receive buffer, writes the transmit buffer.
// - Ninth received bit at control one bit 7, ninth sent bit at 6.
// - Frame length select picks eight or nine data bits, one start, one stop.
// - Wake method select: zero idle line, one address mark.
// - Interrupt from enabled transmit empty, done, full or overrun, idle flags.
// - Transmit enable rising queues one idle character as preamble.
// - Receiver works only while receive enable is one.
// - Break write queues one break character; breaks continue while held.
// - Idle flag sets on idle line; again only after line activity.
// - Buffer-full clears by status read with it set, then data read.
// - Start bit zero after idle high, data LSB first, stop bit one.
// - Sampling clock is sixteen times the bit rate.
`timescale 1ns/100ps
`default_nettype none
module sci_uart_receiver_wakeup import sci_pkg::*; #(
  parameter int RT_DIV = RT_DIV_DEFAULT
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              rxd,
  output logic                   txd,
  output logic                   irq
);
  function automatic logic is_reg(input logic [ADDR_W-1:0] addr, input logic [15:0] idx);
    return addr == {idx, 2'b00};
  endfunction : is_reg

  logic            acc;
  logic            rd_status;
  logic            rd_data;
  logic            wr_data;
  logic            wr_c1;
  logic            wr_c2;
  logic [7:0]      read_val;
  logic            tx_ninth_bit;
  logic            rx_ninth_bit;
  logic            frame_length_select;
  logic            rouse_method_sel;
  logic [7:0]      ctrl_two;
  logic [7:1]      status_flags;
  logic [7:1]      set_vec;
  logic [7:1]      clr_vec;
  logic [7:1]      seen;
  logic [7:0]      rx_buf;
  logic            rx_meta;
  logic            rx_sync;
  logic            rt_tick;
  rx_state_e       rx_state;
  logic [3:0]      rt_cnt;
  logic [3:0]      bit_idx;
  logic [8:0]      rx_sh;
  logic [1:0]      vote_sh;
  logic            frame_noise;
  logic            vote_val;
  logic            vote_noisy;
  logic            vote_now;
  logic            frame_done;
  logic            rx_take;
  logic            transfer;
  logic            am_event;
  logic            idle_event;
  logic            line_active;
  logic [7:0]      quiet_cnt;
  logic [3:0]      data_bits;
  logic [3:0]      frame_bits;
  logic [7:0]      frame_ticks;
  logic [7:0]      tx_buf;
  logic            buf_full;
  logic            te_d;
  logic            pre_pend;
  logic            brk_pend;
  logic [3:0]      tx_rt;
  logic [3:0]      tx_left;
  logic [10:0]     tx_sh;
  logic [10:0]     next_frame;
  logic            tx_boundary;
  logic            load_pre;
  logic            load_brk;
  logic            load_dat;
  logic            loading;

  wire tx_empty_flag = status_flags[ST_TX_EMPTY];
  wire tx_done_flag  = status_flags[ST_TX_DONE];
  wire rx_full_flag  = status_flags[ST_RX_FULL];
  wire line_idle     = status_flags[ST_IDLE];
  wire overrun_flag  = status_flags[ST_OVERRUN];
  wire framing_flag  = status_flags[ST_FRAMING];
  wire rx_sleep      = ctrl_two[C2_SLEEP];
  wire rx_enable     = ctrl_two[C2_RX_EN];
  wire tx_enable     = ctrl_two[C2_TX_EN];
  wire send_break    = ctrl_two[C2_BREAK];

  // Bus slave: one wait state, then the access completes
  assign acc       = psel & penable & pready;
  assign rd_status = acc & ~pwrite & is_reg(paddr, IDX_STATUS);
  assign rd_data   = acc & ~pwrite & is_reg(paddr, IDX_DATA);
  assign wr_data   = acc & pwrite & is_reg(paddr, IDX_DATA);
  assign wr_c1     = acc & pwrite & is_reg(paddr, IDX_CTRL_ONE);
  assign wr_c2     = acc & pwrite & is_reg(paddr, IDX_CTRL_TWO);

  always_comb begin
    read_val = 8'h00;
    if (is_reg(paddr, IDX_CTRL_ONE)) begin
      read_val = {rx_ninth_bit, tx_ninth_bit, 1'b0, frame_length_select, rouse_method_sel, 3'h0};
    end else if (is_reg(paddr, IDX_CTRL_TWO)) begin
      read_val = ctrl_two;
    end else if (is_reg(paddr, IDX_STATUS)) begin
      read_val = {status_flags, 1'b0};
    end else if (is_reg(paddr, IDX_DATA)) begin
      read_val = rx_buf;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready) begin
        prdata  <= {24'h00_0000, read_val};
        pslverr <= ~(is_reg(paddr, IDX_CTRL_ONE) | is_reg(paddr, IDX_CTRL_TWO)
                     | is_reg(paddr, IDX_STATUS) | is_reg(paddr, IDX_DATA));
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_ninth_bit        <= 1'b0;
      frame_length_select <= 1'b0;
      rouse_method_sel    <= 1'b0;
    end else if (wr_c1) begin
      tx_ninth_bit        <= pwdata[C1_TX_NINTH];
      frame_length_select <= pwdata[C1_FRAME_LEN];
      rouse_method_sel    <= pwdata[C1_WAKE];
    end
  end

  // Software write wins over the hardware wakeup in the same cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_two <= CTRL_TWO_RST;
    end else if (wr_c2) begin
      ctrl_two <= pwdata[7:0];
    end else if ((idle_event & ~rouse_method_sel) | am_event) begin
      ctrl_two[C2_SLEEP] <= 1'b0;
    end
  end

  // Receive line synchroniser and sampling tick
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= rxd;
      rx_sync <= rx_meta;
    end
  end

  rt_tick_gen #(.DIV(RT_DIV)) u_rt_tick (
    .ref_clk (ref_clk),
    .rst     (rst),
    .rt_tick (rt_tick)
  );

  bit_vote u_vote (
    .samples ({vote_sh, rx_sync}),
    .value   (vote_val),
    .noisy   (vote_noisy)
  );

  assign data_bits   = frame_length_select ? DATA_BITS_9 : DATA_BITS_8;
  assign frame_bits  = frame_length_select ? FRAME_BITS_9 : FRAME_BITS_8;
  assign frame_ticks = {frame_bits, 4'h0};
  assign vote_now    = rt_tick & rx_enable & (rt_cnt == RT_VOTE_LAST) & (rx_state != RX_IDLE);
  assign frame_done  = vote_now & (rx_state == RX_STOP);
  assign rx_take     = frame_done & ~rx_sleep;
  assign transfer    = rx_take & ~rx_full_flag & ~framing_flag;
  // The last data bit is the mark bit; wake before the stop bit arrives
  assign am_event    = vote_now & (rx_state == RX_DATA) & (bit_idx == data_bits - 4'h1)
                       & vote_val & rouse_method_sel;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_state    <= RX_IDLE;
      rt_cnt      <= 4'h0;
      bit_idx     <= 4'h0;
      rx_sh       <= 9'h000;
      vote_sh     <= 2'h3;
      frame_noise <= 1'b0;
    end else if (!rx_enable) begin
      rx_state <= RX_IDLE;
      rt_cnt   <= 4'h0;
    end else if (rt_tick) begin
      rt_cnt <= rt_cnt + 4'h1;
      if (rt_cnt == RT_VOTE_FIRST || rt_cnt == RT_VOTE_MID) begin
        vote_sh <= {vote_sh[0], rx_sync};
      end
      case (rx_state)
        RX_IDLE: begin
          rt_cnt <= 4'h0;
          if (!rx_sync) begin
            rx_state    <= RX_START;
            rt_cnt      <= 4'h1;
            frame_noise <= 1'b0;
          end
        end
        RX_START: begin
          if (rt_cnt == RT_VOTE_LAST && vote_val) begin
            rx_state <= RX_IDLE;
            rt_cnt   <= 4'h0;
          end else begin
            if (rt_cnt == RT_VOTE_LAST) begin
              frame_noise <= vote_noisy;
            end
            if (rt_cnt == RT_BIT_END) begin
              rx_state <= RX_DATA;
              bit_idx  <= 4'h0;
            end
          end
        end
        RX_DATA: begin
          if (rt_cnt == RT_VOTE_LAST) begin
            rx_sh       <= {vote_val, rx_sh[8:1]};
            frame_noise <= frame_noise | vote_noisy;
          end
          if (rt_cnt == RT_BIT_END) begin
            if (bit_idx == data_bits - 4'h1) begin
              rx_state <= RX_STOP;
            end else begin
              bit_idx <= bit_idx + 4'h1;
            end
          end
        end
        RX_STOP: begin
          if (rt_cnt == RT_VOTE_LAST) begin
            rx_state <= RX_IDLE;
            rt_cnt   <= 4'h0;
          end
        end
        default: begin
          rx_state <= RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_buf       <= 8'h00;
      rx_ninth_bit <= 1'b0;
    end else if (transfer) begin
      rx_buf <= frame_length_select ? rx_sh[7:0] : rx_sh[8:1];
      if (frame_length_select) begin
        rx_ninth_bit <= rx_sh[8];
      end
    end
  end

  // Idle: one whole frame time of high line after activity
  assign idle_event = line_active & rt_tick & rx_enable & rx_sync & (rx_state == RX_IDLE)
                      & (quiet_cnt == frame_ticks - 8'h01);

  always_ff @(posedge ref_clk) begin
    if (rst || rx_state != RX_IDLE || !rx_sync || !rx_enable) begin
      quiet_cnt <= 8'h00;
    end else if (rt_tick && quiet_cnt != frame_ticks) begin
      quiet_cnt <= quiet_cnt + 8'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      line_active <= 1'b0;
    end else if (rx_state == RX_START) begin
      line_active <= 1'b1;
    end else if (idle_event) begin
      line_active <= 1'b0;
    end
  end

  // Transmitter: preamble, break and data frames
  assign tx_boundary = rt_tick & (tx_rt == RT_BIT_END);

  always_comb begin
    load_pre = 1'b0;
    load_brk = 1'b0;
    load_dat = 1'b0;
    if (tx_boundary && tx_left == 4'h0 && tx_enable) begin
      if (pre_pend) begin
        load_pre = 1'b1;
      end else if (brk_pend || send_break) begin
        load_brk = 1'b1;
      end else if (buf_full) begin
        load_dat = 1'b1;
      end
    end
  end

  assign loading    = load_pre | load_brk | load_dat;
  assign next_frame = load_pre ? 11'h7ff :
                      load_brk ? 11'h000 :
                      {1'b1, frame_length_select ? tx_ninth_bit : 1'b1, tx_buf, 1'b0};

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      te_d     <= 1'b0;
      pre_pend <= 1'b0;
      brk_pend <= 1'b0;
    end else begin
      te_d <= tx_enable;
      if (tx_enable && !te_d) begin
        pre_pend <= 1'b1;
      end else if (load_pre) begin
        pre_pend <= 1'b0;
      end
      if (wr_c2 && pwdata[C2_BREAK]) begin
        brk_pend <= 1'b1;
      end else if (load_brk) begin
        brk_pend <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_buf   <= 8'h00;
      buf_full <= 1'b0;
    end else if (wr_data) begin
      tx_buf   <= pwdata[7:0];
      buf_full <= 1'b1;
    end else if (load_dat) begin
      buf_full <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_rt   <= 4'h0;
      tx_left <= 4'h0;
      tx_sh   <= 11'h7ff;
      txd     <= 1'b1;
    end else begin
      if (rt_tick) begin
        tx_rt <= tx_rt + 4'h1;
      end
      if (tx_boundary) begin
        if (tx_left != 4'h0) begin
          txd     <= tx_sh[0];
          tx_sh   <= tx_sh >> 1;
          tx_left <= tx_left - 4'h1;
        end else if (loading) begin
          txd     <= next_frame[0];
          tx_sh   <= next_frame >> 1;
          tx_left <= frame_bits - 4'h1;
        end else begin
          txd <= 1'b1;
        end
      end
    end
  end

  // Status flags: set beats clear in the same cycle
  always_comb begin
    set_vec              = '0;
    set_vec[ST_TX_EMPTY] = load_dat;
    set_vec[ST_TX_DONE]  = tx_boundary & (tx_left == 4'h0) & ~loading;
    set_vec[ST_RX_FULL]  = transfer;
    set_vec[ST_IDLE]     = idle_event & ~rx_sleep;
    set_vec[ST_OVERRUN]  = rx_take & rx_full_flag;
    set_vec[ST_NOISE]    = transfer & (frame_noise | vote_noisy);
    set_vec[ST_FRAMING]  = transfer & ~vote_val;
    clr_vec              = {{2{wr_data}}, {5{rd_data}}} & seen;
  end

  for (genvar i = 1; i < 8; i++) begin : g_flag
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        status_flags[i] <= STATUS_RST[i];
      end else if (set_vec[i]) begin
        status_flags[i] <= 1'b1;
      end else if (clr_vec[i]) begin
        status_flags[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      seen <= '0;
    end else if (rd_status) begin
      seen <= status_flags;
    end else if (rd_data || wr_data) begin
      seen <= '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= (tx_empty_flag & ctrl_two[C2_TX_EMPTY_IE]) | (tx_done_flag & ctrl_two[C2_TX_DONE_IE])
             | ((rx_full_flag | overrun_flag) & ctrl_two[C2_RX_FULL_IE])
             | (line_idle & ctrl_two[C2_QUIET_IE]);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_sleep_blocks_full: assert property ($rose(rx_full_flag) |-> !$past(rx_sleep))
    else $error("buffer-full set while asleep");
  a_overrun_keeps_data: assert property (rx_take && rx_full_flag |=> overrun_flag && $stable(rx_buf))
    else $error("overrun did not keep buffer");
  a_framing_with_full: assert property ($rose(framing_flag) |-> $rose(rx_full_flag))
    else $error("framing flag without buffer-full");
  a_overrun_hides_framing: assert property (rx_take && rx_full_flag && !framing_flag |=> !framing_flag)
    else $error("framing reported with overrun");
  a_framing_blocks_xfer: assert property (framing_flag && !rx_full_flag && rx_take |=> !rx_full_flag)
    else $error("transfer while framing flag set");
  a_full_clear_seq: assert property (rd_data && seen[ST_RX_FULL] && !transfer |=> !rx_full_flag)
    else $error("buffer-full not cleared");
  a_idle_wakeup: assert property (idle_event && !rouse_method_sel && !wr_c2 |=> !rx_sleep)
    else $error("idle line did not wake");
  a_mark_wakeup: assert property (am_event && !wr_c2 |=> !rx_sleep ##0 rx_state == RX_DATA)
    else $error("address mark did not wake");
  a_rx_disabled: assert property (!rx_enable |=> rx_state == RX_IDLE)
    else $error("receiver ran while disabled");
  a_irq_from_full: assert property (rx_full_flag && ctrl_two[C2_RX_FULL_IE] [*2] |-> irq)
    else $error("missing receive interrupt");

  c_overrun: cover property (rx_take && rx_full_flag);
  c_framing: cover property ($rose(framing_flag));
  c_idle_wake: cover property (idle_event && rx_sleep);
  c_mark_wake: cover property (am_event && rx_sleep);
endmodule : sci_uart_receiver_wakeup
`default_nettype wire
